// file: rtl/sscr_defines.svh
/*
  offsets, field positions, reset values and timing counts for the
  socket supply control block.
  assumes: included by bare name from the design file, the bench and the checker.
*/
`ifndef SSCR_DEFINES_SVH
`define SSCR_DEFINES_SVH

// register byte offsets
`define SSCR_SUPPLY_CTRL_OFS 12'h010
`define SSCR_RETEST_OFS 12'h00c
`define SSCR_CARD_TYPE_OFS 12'h014

// supply control field positions
`define SSCR_ZV_ANY_BIT 11
`define SSCR_STD_MODEL_BIT 10
`define SSCR_ZV_EN_BIT 9
`define SSCR_STOP_POL_BIT 7
`define SSCR_VCC_LSB 4
`define SSCR_VPP_LSB 0

// retest bit in the force-event word
`define SSCR_RETEST_BIT 14
// forced card-type bits that disable supply control
`define SSCR_FORCE_TYPE_MSB 13
`define SSCR_FORCE_TYPE_LSB 10

// reset values
`define SSCR_SUPPLY_CTRL_RST 32'h0000_0000

// idle clocks before a clock stop attempt
`define SSCR_IDLE_CLOCKS 8

`endif

// file: rtl/sscr_pkg.sv
/*
  types for the socket supply control block.
  assumes: sscr_defines.svh is on the include path.
*/
package sscr_pkg;
  // card supply request codes
  typedef enum logic [2:0] {
    SSCR_VCC_OFF = 3'h0,
    SSCR_VCC_RSV1 = 3'h1,
    SSCR_VCC_5V = 3'h2,
    SSCR_VCC_3V3 = 3'h3,
    SSCR_VCC_XX = 3'h4,
    SSCR_VCC_YY = 3'h5,
    SSCR_VCC_RSV6 = 3'h6,
    SSCR_VCC_RSV7 = 3'h7
  } sscr_vcc_e;
  // programming supply request codes
  typedef enum logic [2:0] {
    SSCR_VPP_OFF = 3'h0,
    SSCR_VPP_12V = 3'h1,
    SSCR_VPP_5V = 3'h2,
    SSCR_VPP_3V3 = 3'h3,
    SSCR_VPP_XX = 3'h4,
    SSCR_VPP_YY = 3'h5,
    SSCR_VPP_RSV6 = 3'h6,
    SSCR_VPP_RSV7 = 3'h7
  } sscr_vpp_e;
  // one-hot supply selection, bit order: yy, xx, 3v3, 5v, 12v
  typedef logic [4:0] sscr_rail_t;
  // clock stop decision states
  typedef enum logic [1:0] {
    SSCR_CLK_RUN = 2'b00,
    SSCR_CLK_IDLE = 2'b01,
    SSCR_CLK_STOP = 2'b10
  } sscr_clk_e;
endpackage : sscr_pkg

// file: rtl/sscr_socket_ctrl.sv
/*
  socket supply control register with an axi4-lite slave, rail gating
  against a cardbus card's accepted voltages, and the clock stop policy.
  assumes: one clock, synchronous active-high reset for the bus, and
  pin-level reset and status inputs that come from outside the domain.
*/
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "sscr_defines.svh"

module sscr_socket_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins from outside the clock domain
  input wire logic global_reset_input,
  input wire logic host_bus_reset_input,
  input wire logic power_management_wake,
  input wire logic other_socket_video_en,
  input wire logic cardbus_card_present,
  input wire logic [4:0] card_accepted_rails,
  input wire logic socket_busy,
  input wire logic host_clock_stopping,
  // outputs to the power switch, zoomed video and clock logic
  output sscr_pkg::sscr_rail_t card_supply_rail,
  output sscr_pkg::sscr_rail_t programming_supply_rail,
  output logic zoomed_video_enable,
  output logic card_clock_stop_req
);
  import sscr_pkg::*;

  // socket idle count width
  localparam int IDLE_W = 4;
  localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(`SSCR_IDLE_CLOCKS);

  // supply code to one-hot card rail; reserved codes select none
  function automatic sscr_rail_t vcc_rail(input logic [2:0] code);
    sscr_rail_t r;
    r = 5'h00;
    unique case (sscr_vcc_e'(code))
      SSCR_VCC_5V: r = 5'h02;
      SSCR_VCC_3V3: r = 5'h04;
      SSCR_VCC_XX: r = 5'h08;
      SSCR_VCC_YY: r = 5'h10;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : vcc_rail

  // programming code to one-hot rail; reserved codes select none
  function automatic sscr_rail_t vpp_rail(input logic [2:0] code);
    sscr_rail_t r;
    r = 5'h00;
    unique case (sscr_vpp_e'(code))
      SSCR_VPP_12V: r = 5'h01;
      SSCR_VPP_5V: r = 5'h02;
      SSCR_VPP_3V3: r = 5'h04;
      SSCR_VPP_XX: r = 5'h08;
      SSCR_VPP_YY: r = 5'h10;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : vpp_rail

  // two-stage synchronisers for all pin inputs
  logic [11:0] pin_meta_r; // first stage, read only by second
  logic [11:0] pin_sync_r; // second stage
  wire [11:0] pin_raw = {global_reset_input, host_bus_reset_input,
    power_management_wake, other_socket_video_en, cardbus_card_present,
    card_accepted_rails, socket_busy, host_clock_stopping};

  always_ff @(posedge sys_clk) begin
    pin_meta_r <= pin_raw;
    pin_sync_r <= pin_meta_r;
  end

  // synchronised pin names
  wire global_reset_s = pin_sync_r[11];
  wire host_reset_s = pin_sync_r[10];
  wire wake_s = pin_sync_r[9];
  wire other_zv_s = pin_sync_r[8];
  wire cb_card_s = pin_sync_r[7];
  wire [4:0] accepted_s = pin_sync_r[6:2];
  wire busy_s = pin_sync_r[1];
  wire host_stop_s = pin_sync_r[0];

  // writable fields
  logic zv_en_r; // video enable
  logic stop_pol_r; // clock stop policy
  logic [2:0] vcc_r; // card supply request
  logic [2:0] vpp_r; // programming supply request
  logic power_ctrl_dis_r; // set by a forced card-type write

  // axi channel state
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // accept address and data independently, one write at a time
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_r || aw_take;
  wire w_have = w_held_r || w_take;
  wire [11:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire wr_word = wr_addr[11:2] == 10'(`SSCR_SUPPLY_CTRL_OFS >> 2);
  wire wr_retest = wr_addr[11:2] == 10'(`SSCR_RETEST_OFS >> 2);
  wire wr_ok = wr_word || wr_retest;
  wire ctrl_wr = wr_fire && wr_word;
  wire retest_wr = wr_fire && wr_retest;

  // bus reset clears supply requests unless wake holds them
  wire supply_clr = reset ? !wake_s : 1'b0;
  wire supply_rst = global_reset_s || (host_reset_s && !wake_s) ||
    supply_clr;
  wire ctrl_rst = reset || global_reset_s;

  // force-event write: type force disables, retest re-enables
  wire force_type = retest_wr && wr_strb[1] &&
    (|wr_data[`SSCR_FORCE_TYPE_MSB:`SSCR_FORCE_TYPE_LSB]);
  wire retest_hit = retest_wr && wr_strb[1] &&
    wr_data[`SSCR_RETEST_BIT];

  // video and policy fields
  always_ff @(posedge sys_clk) begin
    if (ctrl_rst) begin
      zv_en_r <= 1'b0;
      stop_pol_r <= 1'b0;
    end else if (ctrl_wr) begin
      if (wr_strb[1]) zv_en_r <= wr_data[`SSCR_ZV_EN_BIT];
      if (wr_strb[0]) stop_pol_r <= wr_data[`SSCR_STOP_POL_BIT];
    end
  end

  // supply request fields with their own reset scheme
  always_ff @(posedge sys_clk) begin
    if (supply_rst) begin
      vcc_r <= 3'h0;
      vpp_r <= 3'h0;
    end else if (ctrl_wr && wr_strb[0]) begin
      vcc_r <= wr_data[`SSCR_VCC_LSB+:3];
      vpp_r <= wr_data[`SSCR_VPP_LSB+:3];
    end
  end

  // power control disable; retest wins over a same-cycle force
  always_ff @(posedge sys_clk) begin
    if (ctrl_rst) begin
      power_ctrl_dis_r <= 1'b0;
    end else if (retest_hit) begin
      power_ctrl_dis_r <= 1'b0;
    end else if (force_type) begin
      power_ctrl_dis_r <= 1'b1;
    end
  end

  // rails gated by requests, cardbus card acceptance and power control
  wire [4:0] accept_mask = cb_card_s ? accepted_s : 5'h1f;
  wire rail_allow = !power_ctrl_dis_r;
  wire sscr_rail_t vcc_sel = rail_allow ?
    (vcc_rail(vcc_r) & accept_mask) : 5'h00;
  wire sscr_rail_t vpp_sel = rail_allow ?
    (vpp_rail(vpp_r) & accept_mask) : 5'h00;

  // rail outputs registered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      card_supply_rail <= 5'h00;
      programming_supply_rail <= 5'h00;
      zoomed_video_enable <= 1'b0;
    end else begin
      card_supply_rail <= vcc_sel;
      programming_supply_rail <= vpp_sel;
      zoomed_video_enable <= zv_en_r;
    end
  end

  // readback word
  wire zv_any = zv_en_r || other_zv_s;
  wire [31:0] ctrl_word = {20'h00000, zv_any, 1'b1, zv_en_r, 1'b0,
    stop_pol_r, vcc_r, 1'b0, vpp_r};

  // idle counter and clock stop policy machine
  sscr_clk_e clk_st_r;
  sscr_clk_e clk_st_nxt;
  logic [IDLE_W-1:0] idle_cnt_r;
  wire idle_done = idle_cnt_r == IDLE_MAX;
  wire host_ok = stop_pol_r || host_stop_s;

  always_ff @(posedge sys_clk) begin
    if (reset || busy_s) begin
      idle_cnt_r <= '0;
    end else if (!idle_done) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  // next state for the clock stop decision
  always_comb begin
    clk_st_nxt = clk_st_r;
    unique case (clk_st_r)
      SSCR_CLK_RUN: if (!busy_s) clk_st_nxt = SSCR_CLK_IDLE;
      SSCR_CLK_IDLE: begin
        if (busy_s) clk_st_nxt = SSCR_CLK_RUN;
        else if (idle_done && host_ok) clk_st_nxt = SSCR_CLK_STOP;
      end
      SSCR_CLK_STOP: begin
        if (busy_s || !host_ok) clk_st_nxt = SSCR_CLK_RUN;
      end
      default: clk_st_nxt = SSCR_CLK_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clk_st_r <= SSCR_CLK_RUN;
      card_clock_stop_req <= 1'b0;
    end else begin
      clk_st_r <= clk_st_nxt;
      card_clock_stop_req <= clk_st_nxt == SSCR_CLK_STOP;
    end
  end

  // write channel handshake and response
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) wdata_r <= s_axi_wdata;
      if (w_take) wstrb_r <= s_axi_wstrb;
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else begin
        if (aw_take) aw_held_r <= 1'b1;
        if (w_take) w_held_r <= 1'b1;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready while nothing of that channel is held or answered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !wr_fire && !s_axi_bvalid;
      s_axi_wready <= !w_have && !wr_fire && !s_axi_bvalid;
    end
  end

  // read channel: address taken, data one cycle later
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_word = s_axi_araddr[11:2] ==
    10'(`SSCR_SUPPLY_CTRL_OFS >> 2);
  wire rd_wo = s_axi_araddr[11:2] == 10'(`SSCR_RETEST_OFS >> 2);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word ? ctrl_word : 32'h0000_0000;
        s_axi_rresp <= (rd_word || rd_wo) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // elaboration check: the idle counter must reach the idle span
  if ((2 ** IDLE_W) <= `SSCR_IDLE_CLOCKS) begin : g_idle_w_chk
    $error("idle counter too narrow");
  end
endmodule : sscr_socket_ctrl

// file: verification/socket_supply_control_register_test.sv
/* self-checking bench for the socket supply control block.
   assumes: design, card model and checker compiled first. */
`timescale 1ns/1ns
`include "sscr_defines.svh"
module socket_supply_control_register_test;
  import sscr_pkg::*;
  localparam logic [11:0] sup_ofs = `SSCR_SUPPLY_CTRL_OFS;
  localparam logic [11:0] ret_ofs = `SSCR_RETEST_OFS;
  logic sys_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, insert, active;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic global_reset_input, host_bus_reset_input, power_management_wake;
  logic other_socket_video_en, host_clock_stopping, cardbus_card_present;
  logic socket_busy, zoomed_video_enable, card_clock_stop_req;
  logic [4:0] card_accepted_rails, volts;
  sscr_rail_t card_supply_rail, programming_supply_rail;
  int err_total, comparisons;
  sscr_socket_ctrl DUT (.*);
  sscr_card_model card (.*);
  // free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // one write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr
  // one read; data judged only on an okay answer
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
    if (er == 2'h0) chk(s_axi_rdata, e);
  endtask : rd
  // expected one-hot rail for a request code
  function automatic logic [4:0] rail(input logic [2:0] c, input logic v);
    if (v && c == 3'h1) return 5'h00;
    return (c >= 3'h1 && c <= 3'h5) ? 5'h01 << (c - 3'h1) : 5'h00;
  endfunction : rail
  task automatic t_fields;
    rd(sup_ofs, 32'h400, 2'h0);
    wr(sup_ofs, 32'hffff_ffff, 2'h0);
    rd(sup_ofs, 32'hef7, 2'h0);
    chk(zoomed_video_enable, 32'h1);
    wr(sup_ofs, 32'h0, 2'h0);
    other_socket_video_en <= 1'b1;
    cyc(4);
    rd(sup_ofs, 32'hc00, 2'h0);
    other_socket_video_en <= 1'b0;
    rd(12'h100, 32'h0, 2'h2);
    rd(ret_ofs, 32'h0, 2'h0);
  endtask : t_fields
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      wr(sup_ofs, {25'h0, i[2:0], 1'b0, i[2:0]}, 2'h0);
      cyc(2);
      chk(card_supply_rail, rail(i[2:0], 1'b1));
      chk(programming_supply_rail, rail(i[2:0], 1'b0));
      rd(sup_ofs, 32'h400 | (i << 4) | i, 2'h0);
    end
  endtask : t_codes
  task automatic t_mask;
    insert <= 1'b1;
    volts <= 5'h04;
    wr(sup_ofs, 32'h22, 2'h0);
    cyc(5);
    chk(card_supply_rail, 32'h0);
    wr(sup_ofs, 32'h33, 2'h0);
    cyc(2);
    chk(card_supply_rail, 32'h4);
    wr(ret_ofs, 32'h400, 2'h0);
    cyc(2);
    chk(card_supply_rail, 32'h0);
    wr(ret_ofs, 32'h4000, 2'h0);
    cyc(2);
    chk(programming_supply_rail, 32'h4);
    insert <= 1'b0;
  endtask : t_mask
  task automatic t_resets;
    power_management_wake <= 1'b1;
    cyc(4);
    host_bus_reset_input <= 1'b1;
    cyc(5);
    host_bus_reset_input <= 1'b0;
    rd(sup_ofs, 32'h433, 2'h0);
    // bus reset in mid-run: wake keeps the supply requests
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    rd(sup_ofs, 32'h433, 2'h0);
    global_reset_input <= 1'b1;
    cyc(5);
    global_reset_input <= 1'b0;
    rd(sup_ofs, 32'h400, 2'h0);
    wr(sup_ofs, 32'h33, 2'h0);
    power_management_wake <= 1'b0;
    cyc(4);
    host_bus_reset_input <= 1'b1;
    cyc(5);
    host_bus_reset_input <= 1'b0;
    rd(sup_ofs, 32'h400, 2'h0);
  endtask : t_resets
  task automatic t_clock;
    cyc(20);
    chk(card_clock_stop_req, 32'h0);
    host_clock_stopping <= 1'b1;
    cyc(5);
    chk(card_clock_stop_req, 32'h1);
    active <= 1'b1;
    cyc(8);
    chk(card_clock_stop_req, 32'h0);
    host_clock_stopping <= 1'b0;
    wr(sup_ofs, 32'h80, 2'h0);
    active <= 1'b0;
    cyc(6);
    chk(card_clock_stop_req, 32'h0);
    cyc(10);
    chk(card_clock_stop_req, 32'h1);
  endtask : t_clock
  task automatic complete_run;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, global_reset_input, host_bus_reset_input} = '0;
    {power_management_wake, other_socket_video_en} = '0;
    {host_clock_stopping, insert, active} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, volts} = '0;
    s_axi_wstrb = 4'hf;
    reset = 1'b1;
    cyc(5);
    reset <= 1'b0;
    t_fields;
    t_codes;
    t_mask;
    t_resets;
    t_clock;
    complete_run;
  end
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    #500_000;
    err_total++;
    complete_run;
  end
endmodule : socket_supply_control_register_test

// file: verification/sscr_card_model.sv
/* card side model: presence, accepted voltages and activity.
   assumes: driven by the bench, sampled on sys_clk. */
`timescale 1ns/1ns
module sscr_card_model (
  input wire logic sys_clk,
  input wire logic insert,
  input wire logic [4:0] volts,
  input wire logic active,
  output logic cardbus_card_present,
  output logic [4:0] card_accepted_rails,
  output logic socket_busy
);
  // card pins move on the clock; empty socket pulls sense lines low
  always_ff @(posedge sys_clk) begin
    cardbus_card_present <= insert;
    card_accepted_rails <= insert ? volts : 5'h00;
    socket_busy <= active;
  end
endmodule : sscr_card_model

// file: verification/sscr_socket_ctrl_asserts.sv
/* port checker for the socket supply control block, with its bind.
   assumes: one clock, synchronous active-high reset. */
`timescale 1ns/1ns
`include "sscr_defines.svh"
module sscr_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic cardbus_card_present,
  input wire logic [4:0] card_accepted_rails,
  input wire logic socket_busy,
  input wire sscr_pkg::sscr_rail_t card_supply_rail,
  input wire sscr_pkg::sscr_rail_t programming_supply_rail,
  input wire logic zoomed_video_enable,
  input wire logic card_clock_stop_req
);
  import sscr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic sup_r; // pending read targets the supply register
  wire sup_rd = s_axi_rvalid && sup_r;
  // remember which register the read asked for
  always_ff @(posedge sys_clk)
    if (s_axi_arvalid && s_axi_arready)
      sup_r <= s_axi_araddr == `SSCR_SUPPLY_CTRL_OFS;
  sequence card_settled;
    cardbus_card_present && $stable(card_accepted_rails);
  endsequence
  sequence busy_held;
    socket_busy [*6];
  endsequence
  a_reserved_zero: assert property (
    sup_rd |-> !s_axi_rdata[31:12] && !s_axi_rdata[8] && !s_axi_rdata[3])
    else $error("reserved bits not zero");
  a_model_flags: assert property (
    sup_rd |-> s_axi_rdata[10] && (s_axi_rdata[11] || !s_axi_rdata[9]))
    else $error("video flags wrong");
  a_video_copy: assert property (
    sup_rd |-> s_axi_rdata[9] == zoomed_video_enable)
    else $error("video enable output wrong");
  a_vcc_reserved: assert property (
    sup_rd && s_axi_rdata[6:4] inside {3'h1, 3'h6, 3'h7}
    |-> card_supply_rail == 5'h00)
    else $error("reserved card code powers rail");
  a_vpp_reserved: assert property (
    sup_rd && s_axi_rdata[2:0] inside {3'h6, 3'h7}
    |-> programming_supply_rail == 5'h00)
    else $error("reserved prog code powers rail");
  a_rail_onehot: assert property (
    $onehot0(card_supply_rail) && $onehot0(programming_supply_rail))
    else $error("rail not one-hot");
  a_rail_mask: assert property (
    card_settled [*4] |-> ((card_supply_rail | programming_supply_rail)
    & ~card_accepted_rails) == 5'h00)
    else $error("rail outside accepted set");
  a_busy_no_stop: assert property (
    busy_held |-> !card_clock_stop_req)
    else $error("stop while busy");
  a_idle_before_stop: assert property (
    $rose(card_clock_stop_req)
    |-> !$past(socket_busy, 8) && !$past(socket_busy, 3))
    else $error("stop before idle span");
endmodule : sscr_checker
bind sscr_socket_ctrl sscr_checker chk_i (.*);
